// ===== hdl/mftc_mode_ctrl.sv
// mftc_mode_ctrl: mode control register of a multifunction timer with
// the counter unit it steers (prescaler, two counters, reloads, flags).
// assumes a single-cycle register port and asynchronous timer pins.
//
// Function
// - output-level bit drives chan A in PWM
// - software write beats hardware toggle
// - level bit inert if input or disabled
// - enable bit; disabled stops counter clocks
// - disabled: counter, reload, flag writes ignored
// - disabled: prescaler and flags held reset
// - disabled: chan A pin becomes input
// - select bit plus mode 00b: pulse train
// - select bit inert outside mode 00b
// - soft trigger: start on event-bit write
// - no soft trigger: chan B edge starts
// - soft enable inert outside pulse-train mode
// - chan B input enable bit gates pin
// - counter two underflow clears event bit in pulse train
// - event-bit writes ignored in pulse train without soft enable
`timescale 1ns/1ps
`default_nettype none
module mftc_mode_ctrl #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic        chan_a_pin_i,
  output var  logic        chan_a_pin_o,
  output var  logic        chan_a_pin_oe,
  input  wire logic        chan_b_pin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0]       operating_mode_field_r;
  logic             a_edge_rise_r;
  logic             b_edge_rise_r;
  logic             chan_a_en_r;
  logic             chan_b_input_enable_r;
  logic             chan_a_output_level_r;
  logic             timer_unit_enable_r;
  logic             pulse_train_mode_select_r;
  logic             pulse_train_soft_trigger_enable_r;
  logic             pulse_train_event_trigger_r;
  logic [CNT_W-1:0] counter_one_r;
  logic [CNT_W-1:0] counter_two_r;
  logic [CNT_W-1:0] capture_reload_a_r;
  logic [CNT_W-1:0] capture_reload_b_r;
  logic [7:0]       presc_div_r;
  logic [7:0]       presc_cnt_r;
  logic [3:0]       interrupt_pending_flags_r;
  logic             oe_r;
  logic [31:0]      rdata_r;

  logic             a_edge;
  logic             b_edge;
  logic             wr_ctrl;
  logic             pt_mode;
  logic             tick;
  logic             cnt_go;
  logic             c1_uf;
  logic             c2_dec;
  logic             c2_uf;
  logic             trig_wr_ok;
  logic             b_start;
  logic [3:0]       pend_set;
  logic [3:0]       pend_clr;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  mftc_pin_edge u_a_edge (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .pin       (chan_a_pin_i),
    .rising_sel(a_edge_rise_r),
    .edge_seen (a_edge)
  );

  mftc_pin_edge u_b_edge (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .pin       (chan_b_pin),
    .rising_sel(b_edge_rise_r),
    .edge_seen (b_edge)
  );

  // ----------------------------------------------------------------
  // decode and counter-unit timing
  // ----------------------------------------------------------------
  // pulse-train mode only with mode field 00b
  always_comb begin
    wr_ctrl = reg_wr && (reg_addr == mftc_pkg::OFS_MODE_CTRL);
    pt_mode = pulse_train_mode_select_r &&
              (operating_mode_field_r == mftc_pkg::MODE_PWM);
    tick    = timer_unit_enable_r && (presc_cnt_r == presc_div_r);
    // pulse train counts only while a train is in flight
    cnt_go  = tick && (!pt_mode || pulse_train_event_trigger_r);
    c1_uf   = cnt_go && (counter_one_r == '0);
    // in mode 00b counter two counts finished pulses of a pulse train only (high phase end)
    c2_dec  = (operating_mode_field_r == mftc_pkg::MODE_PWM) ?
              (pt_mode && c1_uf && chan_a_output_level_r) : tick;
    c2_uf   = c2_dec && (counter_two_r == '0);
  end

  // trigger handling; soft enable only matters in pulse-train mode
  always_comb begin
    trig_wr_ok = !(pt_mode && !pulse_train_soft_trigger_enable_r);
    b_start    = pt_mode && !pulse_train_soft_trigger_enable_r &&
                 chan_b_input_enable_r && b_edge;
  end

  // ----------------------------------------------------------------
  // mode control register
  // ----------------------------------------------------------------
  // whole-word write; reserved bits are dropped
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      operating_mode_field_r            <= 2'h0;
      a_edge_rise_r                     <= 1'b0;
      b_edge_rise_r                     <= 1'b0;
      chan_a_en_r                       <= 1'b0;
      chan_b_input_enable_r             <= 1'b0;
      timer_unit_enable_r               <= 1'b0;
      pulse_train_mode_select_r         <= 1'b0;
      pulse_train_soft_trigger_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      operating_mode_field_r <= reg_wdata[mftc_pkg::F_MODE_HI:mftc_pkg::F_MODE_LO];
      a_edge_rise_r                     <= reg_wdata[mftc_pkg::F_A_EDGE];
      b_edge_rise_r                     <= reg_wdata[mftc_pkg::F_B_EDGE];
      chan_a_en_r                       <= reg_wdata[mftc_pkg::F_A_EN];
      chan_b_input_enable_r             <= reg_wdata[mftc_pkg::F_B_EN];
      timer_unit_enable_r               <= reg_wdata[mftc_pkg::F_ENABLE];
      pulse_train_mode_select_r         <= reg_wdata[mftc_pkg::F_PT_SEL];
      pulse_train_soft_trigger_enable_r <= reg_wdata[mftc_pkg::F_PT_SOFT];
    end
  end

  // level bit: hardware toggles it, a same-cycle write wins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      chan_a_output_level_r <= 1'b0;
    end else if (wr_ctrl) begin
      chan_a_output_level_r <= reg_wdata[mftc_pkg::F_A_LEVEL];
    end else if (c1_uf && chan_a_en_r &&
                 operating_mode_field_r == mftc_pkg::MODE_PWM) begin
      chan_a_output_level_r <= ~chan_a_output_level_r;
    end
  end

  // event bit: external start sets, underflow clears, write if allowed
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_train_event_trigger_r <= 1'b0;
    end else if (b_start) begin
      pulse_train_event_trigger_r <= 1'b1;
    end else if (wr_ctrl && trig_wr_ok) begin
      pulse_train_event_trigger_r <= reg_wdata[mftc_pkg::F_PT_TRIG];
    end else if (c2_uf && pt_mode) begin
      pulse_train_event_trigger_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // count held at reset value whenever the unit is off
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      presc_cnt_r <= mftc_pkg::PRESC_RESET;
    end else if (!timer_unit_enable_r) begin
      presc_cnt_r <= mftc_pkg::PRESC_RESET;
    end else if (tick) begin
      presc_cnt_r <= mftc_pkg::PRESC_RESET;
    end else begin
      presc_cnt_r <= presc_cnt_r + 8'h01;
    end
  end

  // divider setting, writable at any time
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      presc_div_r <= mftc_pkg::PRESC_RESET;
    end else if (reg_wr && reg_addr == mftc_pkg::OFS_PRESC) begin
      presc_div_r <= reg_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // counters and reload registers
  // ----------------------------------------------------------------
  // counter one: high phase reloads from A, low phase from B
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      counter_one_r <= mftc_pkg::CNT_RESET;
    end else if (reg_wr && timer_unit_enable_r &&
                 reg_addr == mftc_pkg::OFS_CNT_ONE) begin
      counter_one_r <= reg_wdata[CNT_W-1:0];
    end else if (c1_uf) begin
      counter_one_r <= (operating_mode_field_r == mftc_pkg::MODE_PWM &&
                        chan_a_output_level_r) ? capture_reload_b_r
                                               : capture_reload_a_r;
    end else if (cnt_go) begin
      counter_one_r <= counter_one_r - 1'b1;
    end
  end

  // counter two: pulse count in pulse train, held in plain PWM, free timer in other modes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      counter_two_r <= mftc_pkg::CNT_RESET;
    end else if (reg_wr && timer_unit_enable_r &&
                 reg_addr == mftc_pkg::OFS_CNT_TWO) begin
      counter_two_r <= reg_wdata[CNT_W-1:0];
    end else if (c2_uf) begin
      counter_two_r <= capture_reload_b_r;
    end else if (c2_dec) begin
      counter_two_r <= counter_two_r - 1'b1;
    end
  end

  // reload registers, frozen to software while disabled
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      capture_reload_a_r <= mftc_pkg::CNT_RESET;
      capture_reload_b_r <= mftc_pkg::CNT_RESET;
    end else if (reg_wr && timer_unit_enable_r) begin
      if (reg_addr == mftc_pkg::OFS_CR_A) begin
        capture_reload_a_r <= reg_wdata[CNT_W-1:0];
      end
      if (reg_addr == mftc_pkg::OFS_CR_B) begin
        capture_reload_b_r <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // pending flags
  // ----------------------------------------------------------------
  always_comb begin
    pend_set = '0;
    pend_set[mftc_pkg::P_C1_UF]  = c1_uf;
    pend_set[mftc_pkg::P_B_EDGE] = b_edge && chan_b_input_enable_r;
    pend_set[mftc_pkg::P_A_EDGE] = a_edge && !oe_r && chan_a_en_r;
    pend_set[mftc_pkg::P_C2_UF]  = c2_uf;
    pend_clr = (reg_wr && timer_unit_enable_r && reg_addr == mftc_pkg::OFS_PEND_CLR) ?
               reg_wdata[3:0] : 4'h0;
  end

  // set beats a same-cycle clear; off means held clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_pending_flags_r <= 4'h0;
    end else if (!timer_unit_enable_r) begin
      interrupt_pending_flags_r <= 4'h0;
    end else begin
      interrupt_pending_flags_r <= (interrupt_pending_flags_r & ~pend_clr) | pend_set;
    end
  end

  // ----------------------------------------------------------------
  // chan A drive and read port
  // ----------------------------------------------------------------
  // drive only as PWM output of an enabled unit
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= timer_unit_enable_r && chan_a_en_r &&
              operating_mode_field_r == mftc_pkg::MODE_PWM;
    end
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= mftc_pkg::RDATA_UNMAP;
    end else if (reg_rd) begin
      rdata_r <= mftc_pkg::RDATA_UNMAP;
      unique case (reg_addr)
        mftc_pkg::OFS_MODE_CTRL: rdata_r <= {21'h0, pulse_train_event_trigger_r,
          pulse_train_soft_trigger_enable_r, pulse_train_mode_select_r,
          timer_unit_enable_r, chan_a_output_level_r, chan_b_input_enable_r,
          chan_a_en_r, b_edge_rise_r, a_edge_rise_r, operating_mode_field_r};
        mftc_pkg::OFS_CNT_ONE:  rdata_r[CNT_W-1:0] <= counter_one_r;
        mftc_pkg::OFS_CNT_TWO:  rdata_r[CNT_W-1:0] <= counter_two_r;
        mftc_pkg::OFS_CR_A:     rdata_r[CNT_W-1:0] <= capture_reload_a_r;
        mftc_pkg::OFS_CR_B:     rdata_r[CNT_W-1:0] <= capture_reload_b_r;
        mftc_pkg::OFS_PEND:     rdata_r[3:0] <= interrupt_pending_flags_r;
        mftc_pkg::OFS_PRESC:    rdata_r[7:0] <= presc_div_r;
        default:                rdata_r <= mftc_pkg::RDATA_UNMAP;
      endcase
    end else begin
      rdata_r <= mftc_pkg::RDATA_UNMAP;
    end
  end

  // pin level is the level bit itself, so the two never disagree
  always_comb begin
    reg_rdata     = rdata_r;
    chan_a_pin_o  = chan_a_output_level_r;
    chan_a_pin_oe = oe_r;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_OE_OFF_DIS: assert property (@(posedge core_clk) disable iff (!resetn)
    !timer_unit_enable_r |=> !chan_a_pin_oe)
    else $error("chan A still driven while unit disabled");

  AST_PRESC_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !timer_unit_enable_r |=> presc_cnt_r == mftc_pkg::PRESC_RESET)
    else $error("prescaler not held while disabled");

  AST_PEND_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    !timer_unit_enable_r ##1 !timer_unit_enable_r |-> interrupt_pending_flags_r == 4'h0)
    else $error("pending flags not held while disabled");

  AST_CNT_WR_BLOCK: assert property (@(posedge core_clk) disable iff (!resetn)
    (reg_wr && !timer_unit_enable_r && reg_addr == mftc_pkg::OFS_CNT_ONE)
    |=> $stable(counter_one_r))
    else $error("counter one took a write while disabled");

  AST_SW_WINS: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_ctrl |=> chan_a_output_level_r == $past(reg_wdata[mftc_pkg::F_A_LEVEL]))
    else $error("level bit lost a software write");

  AST_PTET_IGNORE: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_ctrl && pt_mode && !pulse_train_soft_trigger_enable_r && !b_start &&
     !pulse_train_event_trigger_r) |=> !pulse_train_event_trigger_r)
    else $error("event bit written without soft enable");

  AST_PTET_CLR: assert property (@(posedge core_clk) disable iff (!resetn)
    (c2_uf && pt_mode && !wr_ctrl && !b_start) |=> !pulse_train_event_trigger_r)
    else $error("event bit kept after counter two underflow");

  AST_NO_PULSE_IDLE: assert property (@(posedge core_clk) disable iff (!resetn)
    (pt_mode && !pulse_train_event_trigger_r && !wr_ctrl)
    |=> $stable(chan_a_output_level_r))
    else $error("pulse produced with no trigger");

  AST_BEDGE_START: assert property (@(posedge core_clk) disable iff (!resetn)
    (pt_mode && !pulse_train_soft_trigger_enable_r && chan_b_input_enable_r && b_edge)
    |=> pulse_train_event_trigger_r)
    else $error("chan B edge did not start a train");

endmodule : mftc_mode_ctrl
`default_nettype wire

// ===== shared/mftc_pkg.sv
// mftc_pkg: register map, field positions and reset values of the
// timer mode control block.
// assumes a byte-addressed plain register port with 32-bit words.
package mftc_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  OFS_MODE_CTRL = 8'h00;
  localparam logic [7:0]  OFS_CNT_ONE   = 8'h04;
  localparam logic [7:0]  OFS_CNT_TWO   = 8'h08;
  localparam logic [7:0]  OFS_CR_A      = 8'h0c;
  localparam logic [7:0]  OFS_CR_B      = 8'h10;
  localparam logic [7:0]  OFS_PEND      = 8'h14;
  localparam logic [7:0]  OFS_PEND_CLR  = 8'h18;
  localparam logic [7:0]  OFS_PRESC     = 8'h1c;

  // ----------------------------------------------------------------
  // mode control field positions
  // ----------------------------------------------------------------
  localparam int unsigned F_MODE_LO  = 0;
  localparam int unsigned F_MODE_HI  = 1;
  localparam int unsigned F_A_EDGE   = 2;
  localparam int unsigned F_B_EDGE   = 3;
  localparam int unsigned F_A_EN     = 4;
  localparam int unsigned F_B_EN     = 5;
  localparam int unsigned F_A_LEVEL  = 6;
  localparam int unsigned F_ENABLE   = 7;
  localparam int unsigned F_PT_SEL   = 8;
  localparam int unsigned F_PT_SOFT  = 9;
  localparam int unsigned F_PT_TRIG  = 10;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_PWM     = 2'h0;
  localparam int unsigned PEND_W       = 4;
  localparam int unsigned P_C1_UF      = 0;
  localparam int unsigned P_B_EDGE     = 1;
  localparam int unsigned P_A_EDGE     = 2;
  localparam int unsigned P_C2_UF      = 3;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [7:0]  PRESC_RESET  = 8'h00;
  localparam logic [31:0] RDATA_UNMAP  = 32'h0000_0000;

endpackage : mftc_pkg

// ===== hdl/mftc_pin_edge.sv
// mftc_pin_edge: two-flop synchroniser and selectable edge detector
// for one timer pin.
// assumes pin is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module mftc_pin_edge (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic pin,
  input  wire logic rising_sel,
  output var  logic edge_seen
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ----------------------------------------------------------------
  // synchroniser: only sync_r reads meta_r
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // edge pulse, one cycle, polarity from the edge select
  always_comb begin
    edge_seen = rising_sel ? (sync_r & ~prev_r) : (~sync_r & prev_r);
  end

endmodule : mftc_pin_edge
`default_nettype wire

// ===== verification/mftc_pin_model.sv
// mftc_pin_model: far side of the timer pins, chan A and chan B.
// assumes the bench sets the chan B level and reads the resolved chan A wire.
`timescale 1ns/1ps
`default_nettype none
module mftc_pin_model (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic chan_a_pin_o,
  input  wire logic chan_a_pin_oe,
  input  wire logic b_level,
  output var  logic chan_a_pin_i,
  output var  logic chan_b_pin
);
  // ----------------------------------------------------------------
  // chan A wire
  // ----------------------------------------------------------------
  logic a_rel_r;

  // released wire has no pull, so show the inverse of the last drive
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      a_rel_r <= 1'b1;
    end else if (chan_a_pin_oe) begin
      a_rel_r <= ~chan_a_pin_o;
    end
  end

  // wire level from the drive enable
  assign chan_a_pin_i = chan_a_pin_oe ? chan_a_pin_o : a_rel_r;
  // chan B is driven by the far side only
  assign chan_b_pin   = b_level;
endmodule : mftc_pin_model
`default_nettype wire

// ===== verification/test_timer_mode_control_bits.sv
// test_timer_mode_control_bits: register-level bench of the mode control
// block. assumes the pin model on the far side and a 100 MHz core_clk.
`timescale 1ns/1ps
`default_nettype none
module test_timer_mode_control_bits;
  logic        core_clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        a_i;
  logic        a_o;
  logic        a_oe;
  logic        b_pin;
  logic        b_level;
  logic [31:0] d;
  logic [31:0] d2;
  int          fail_count;
  int          n_compared;
  int          cycles;

  mftc_mode_ctrl #(.CNT_W(16)) DUT (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .chan_a_pin_i(a_i), .chan_a_pin_o(a_o),
    .chan_a_pin_oe(a_oe), .chan_b_pin(b_pin));
  mftc_pin_model pins (.core_clk(core_clk), .resetn(resetn), .chan_a_pin_o(a_o),
    .chan_a_pin_oe(a_oe), .b_level(b_level), .chan_a_pin_i(a_i), .chan_b_pin(b_pin));

  // ----------------------------------------------------------------
  // clock, timeout and report
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ceiling well above the few hundred cycles the sequence needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      test_done();
    end
  end

  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  // ----------------------------------------------------------------
  // register port master
  // ----------------------------------------------------------------
  // whole-word write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // a full chan B rising edge, long enough for the synchroniser
  task automatic b_edge();
    @(posedge core_clk);
    b_level <= 1'b0;
    repeat (4) @(posedge core_clk);
    b_level <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : b_edge

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0; reg_rd = 1'b0; b_level = 1'b0;
    fail_count = 0; n_compared = 0; cycles = 0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    rd(mftc_pkg::OFS_MODE_CTRL, d); check_word(d, 32'h0000_0000);
    check_bit(a_oe, 1'b0);
    // disabled: writes blocked, flags held clear
    wr(mftc_pkg::OFS_CNT_ONE, 32'h0000_1234);
    rd(mftc_pkg::OFS_CNT_ONE, d); check_word(d, 32'h0000_0000);
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_0028);
    b_edge();
    rd(mftc_pkg::OFS_PEND, d); check_word(d, 32'h0000_0000);
    // pulse train with soft trigger idle: counter stands, B edge no start
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_03A8);
    wr(mftc_pkg::OFS_CNT_ONE, 32'h0000_1234);
    b_edge();
    rd(mftc_pkg::OFS_CNT_ONE, d); check_word(d, 32'h0000_1234);
    rd(mftc_pkg::OFS_MODE_CTRL, d); check_word(d, 32'h0000_03A8);
    rd(mftc_pkg::OFS_PEND, d); check_word(d, 32'h0000_0002);
    // event bit write refused once the soft enable already stands cleared
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_01A8);
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_05A8);
    rd(mftc_pkg::OFS_MODE_CTRL, d); check_word(d, 32'h0000_01A8);
    // outside mode 00 the select and soft bits are inert, event bit stored
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_0181);
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_0781);
    rd(mftc_pkg::OFS_MODE_CTRL, d); check_word(d, 32'h0000_0781);
    // chan B edge starts the train when soft trigger is off
    wr(mftc_pkg::OFS_PEND_CLR, 32'h0000_000F);
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_01A8);
    wr(mftc_pkg::OFS_CNT_ONE, 32'h0000_1234);
    b_edge();
    rd(mftc_pkg::OFS_MODE_CTRL, d); check_word(d, 32'h0000_05A8);
    // chan B input disabled: no B edge flag
    wr(mftc_pkg::OFS_PEND_CLR, 32'h0000_000F);
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_0188);
    b_edge();
    rd(mftc_pkg::OFS_PEND, d); check_word(d & 32'h0000_0002, 32'h0000_0000);
    // soft trigger: leave pulse train first so the event bit can be cleared
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_0391);
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_0390);
    wr(mftc_pkg::OFS_CR_A, 32'h0000_0002);
    wr(mftc_pkg::OFS_CR_B, 32'h0000_0002);
    wr(mftc_pkg::OFS_CNT_TWO, 32'h0000_0001);
    wr(mftc_pkg::OFS_CNT_ONE, 32'h0000_0020);
    rd(mftc_pkg::OFS_CNT_ONE, d); check_word(d, 32'h0000_0020);
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_0790);
    repeat (4) @(posedge core_clk);
    rd(mftc_pkg::OFS_CNT_ONE, d); check_bit(d !== 32'h0000_0020, 1'b1);
    for (int i = 0; i < 300; i++) begin
      rd(mftc_pkg::OFS_MODE_CTRL, d);
      if (d[10] === 1'b0) break;
    end
    check_bit(d[10], 1'b0);
    // plain PWM: load while stopped, so the first toggle lands at a known cycle
    wr(mftc_pkg::OFS_CR_A, 32'h0000_0080);
    wr(mftc_pkg::OFS_CR_B, 32'h0000_0080);
    wr(mftc_pkg::OFS_CNT_ONE, 32'h0000_0004);
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_0090);
    repeat (20) @(posedge core_clk);
    rd(mftc_pkg::OFS_MODE_CTRL, d); check_bit(d[6], 1'b1);
    check_bit(a_o, 1'b1);
    check_bit(a_oe, 1'b1);
    // disable: pin released and counter frozen
    wr(mftc_pkg::OFS_MODE_CTRL, 32'h0000_0050);
    repeat (2) @(posedge core_clk);
    check_bit(a_oe, 1'b0);
    rd(mftc_pkg::OFS_CNT_ONE, d);
    repeat (10) @(posedge core_clk);
    rd(mftc_pkg::OFS_CNT_ONE, d2); check_word(d2, d);
    // reload writes refused and flags held clear while off
    wr(mftc_pkg::OFS_CR_A, 32'h0000_0011);
    rd(mftc_pkg::OFS_CR_A, d); check_word(d, 32'h0000_0080);
    rd(mftc_pkg::OFS_PEND, d); check_word(d, 32'h0000_0000);
    test_done();
  end
endmodule : test_timer_mode_control_bits
`default_nettype wire
